// ===== lba_pkg.sv
// Purpose: shared constants and types for the leaky-bucket activity alarm
// Assumes: 20 MHz system clock, AHB-Lite register access with 32-bit words
// Notes: register offsets are word indices; byte address is four times the index
package lba_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int MON_CYCLE_MS = 128;
    localparam int MON_CYCLE_CLKS = MON_CYCLE_MS * (CLK_HZ / 1000);

    // ------------------------------------------------------------
    // register indices and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_SET_LEVEL = 8'h50;
    localparam logic [7:0] IDX_CLEAR_LEVEL = 8'h51;
    localparam logic [7:0] IDX_DECAY = 8'h53;
    localparam logic [7:0] IDX_STATUS = 8'h60;
    localparam logic [7:0] IDX_MASK = 8'h61;
    localparam logic [7:0] IDX_STATE = 8'h62;
    localparam logic [7:0] RST_SET_LEVEL = 8'h06;
    localparam logic [7:0] RST_CLEAR_LEVEL = 8'h04;
    localparam logic [1:0] RST_DECAY = 2'h1;
    localparam logic [1:0] RST_MASK = 2'h0;

    // ------------------------------------------------------------
    // field layouts
    // ------------------------------------------------------------
    localparam int ST_W = 2;
    localparam int ST_RAISE = 0;
    localparam int ST_CLEAR = 1;
    localparam int DECAY_W = 2;
    localparam int STATE_ALARM_BIT = 8;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 9;

    // ------------------------------------------------------------
    // bus encodings
    // ------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef struct packed {
        logic sel;
        logic [31:0] addr;
        logic [1:0] trans;
        logic write;
        logic [2:0] size;
        logic ready;
    } lba_ahb_req_t;

    typedef struct packed {
        logic rd_stb;
        logic [7:0] rd_idx;
        logic wr_stb;
        logic [7:0] wr_idx;
    } lba_reg_acc_t;

endpackage

// ===== lba_tick_gen.sv
// Purpose: one-cycle pulse at the end of every monitoring cycle
// Assumes: enable freezes the count
// Notes: period is a parameter so that simulation can shorten it
module lba_tick_gen #(
    parameter int PERIOD = lba_pkg::MON_CYCLE_CLKS
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    output logic o_tick
);
    localparam int CW = $clog2(PERIOD);

    initial begin
        if (PERIOD < 2) begin
            $error("lba_tick_gen: PERIOD must be at least 2");
        end
    end

    logic [CW-1:0] cnt;
    wire last = (cnt == CW'(PERIOD - 1));
    wire [CW-1:0] next_cnt = last ? '0 : cnt + 1'b1;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cnt <= '0;
            o_tick <= 1'b0;
        end else if (i_ce) begin
            cnt <= next_cnt;
            o_tick <= last;
        end
    end

    // tick only after a full count of the period
    a_tick_spacing: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(o_tick) |-> $past(cnt) == CW'(PERIOD - 1))
        else $error("tick without full monitoring period");
endmodule

// ===== lba_ahb_front.sv
// Purpose: AHB-Lite address and data phase tracking for the register file
// Assumes: single word transfers, zero wait states
// Notes: reads are strobed in the address phase so data stand in the data phase
module lba_ahb_front (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire lba_pkg::lba_ahb_req_t i_req,
    output lba_pkg::lba_reg_acc_t o_acc
);
    logic ph_valid;
    logic [7:0] ph_idx;

    wire accept = i_req.sel && i_req.ready && (i_req.trans == lba_pkg::HTRANS_NONSEQ)
        && (i_req.size == lba_pkg::HSIZE_WORD);
    wire [7:0] a_idx = i_req.addr[lba_pkg::IDX_MSB:lba_pkg::IDX_LSB];
    wire mapped = (i_req.addr[31:lba_pkg::IDX_MSB+1] == '0) && (i_req.addr[1:0] == 2'h0);

    assign o_acc.rd_stb = accept && !i_req.write && mapped && i_ce;
    assign o_acc.rd_idx = a_idx;
    assign o_acc.wr_stb = ph_valid && i_ce;
    assign o_acc.wr_idx = ph_idx;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ph_valid <= 1'b0;
            ph_idx <= 8'h00;
        end else if (i_ce) begin
            ph_valid <= accept && i_req.write && mapped;
            ph_idx <= a_idx;
        end
    end

    a_write_follows: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && accept && i_req.write && mapped) ##1 i_ce |-> o_acc.wr_stb)
        else $error("write address phase not followed by write strobe");
endmodule

// ===== lba_alarm.sv
// Purpose: leaky-bucket inactivity alarm for one monitored input, with registers
// Assumes: i_fail is synchronous to I_MCLK and high while the input is failed or erratic
// Notes: zero wait state AHB-Lite slave; unmapped reads return zero, writes ignored
//
// Decided for this implementation: the AHB-Lite register port.

// ------------------------------------------------------------
// rule summary
// ------------------------------------------------------------
// How it works
// - judge the input once per 128 ms cycle, remembering any failure inside it
// - add one to the bucket for each cycle that saw failure
// - subtract one per clean period of 1, 2, 4 or 8 cycles
// - clear the alarm once the bucket falls to the lower level
// - upper level resets to six
// - lower level resets to four
module lba_alarm #(
    parameter int CYCLE_CLKS = lba_pkg::MON_CYCLE_CLKS
) (
    input wire logic I_MCLK,
    input wire logic I_RST_N,
    input wire logic I_CE,
    input wire logic I_FAIL,
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    output logic [31:0] O_HRDATA,
    output logic O_HREADYOUT,
    output logic O_HRESP,
    output logic O_ALARM,
    output logic O_IRQ
);
    initial begin
        if (CYCLE_CLKS < 2) begin
            $error("lba_alarm: CYCLE_CLKS must be at least 2");
        end
    end

    // ------------------------------------------------------------
    // bus front end
    // ------------------------------------------------------------
    lba_pkg::lba_ahb_req_t req;
    lba_pkg::lba_reg_acc_t acc;

    assign req.sel = I_HSEL;
    assign req.addr = I_HADDR;
    assign req.trans = I_HTRANS;
    assign req.write = I_HWRITE;
    assign req.size = I_HSIZE;
    assign req.ready = I_HREADY;

    lba_ahb_front u_front (
        .i_clk(I_MCLK),
        .i_rst_n(I_RST_N),
        .i_ce(I_CE),
        .i_req(req),
        .o_acc(acc)
    );

    // ------------------------------------------------------------
    // monitoring cycle timer
    // ------------------------------------------------------------
    logic tick;

    lba_tick_gen #(
        .PERIOD(CYCLE_CLKS)
    ) u_tick (
        .i_clk(I_MCLK),
        .i_rst_n(I_RST_N),
        .i_ce(I_CE),
        .o_tick(tick)
    );

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] set_level;
    logic [7:0] clear_level;
    logic [lba_pkg::DECAY_W-1:0] decay_rate;
    logic [lba_pkg::ST_W-1:0] status;
    logic [lba_pkg::ST_W-1:0] irq_mask;

    wire wr_set = acc.wr_stb && (acc.wr_idx == lba_pkg::IDX_SET_LEVEL);
    wire wr_clear = acc.wr_stb && (acc.wr_idx == lba_pkg::IDX_CLEAR_LEVEL);
    wire wr_decay = acc.wr_stb && (acc.wr_idx == lba_pkg::IDX_DECAY);
    wire wr_mask = acc.wr_stb && (acc.wr_idx == lba_pkg::IDX_MASK);
    wire rd_status = acc.rd_stb && (acc.rd_idx == lba_pkg::IDX_STATUS);

    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            set_level <= lba_pkg::RST_SET_LEVEL;
            clear_level <= lba_pkg::RST_CLEAR_LEVEL;
            decay_rate <= lba_pkg::RST_DECAY;
            irq_mask <= lba_pkg::RST_MASK;
        end else if (I_CE) begin
            if (wr_set) begin
                set_level <= I_HWDATA[7:0];
            end
            if (wr_clear) begin
                clear_level <= I_HWDATA[7:0];
            end
            if (wr_decay) begin
                decay_rate <= I_HWDATA[lba_pkg::DECAY_W-1:0];
            end
            if (wr_mask) begin
                irq_mask <= I_HWDATA[lba_pkg::ST_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // failure capture over one monitoring cycle
    // ------------------------------------------------------------
    // a failure in the tick cycle itself counts for the closing cycle
    logic fail_seen;
    wire cycle_failed = fail_seen || I_FAIL;

    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            fail_seen <= 1'b0;
        end else if (I_CE) begin
            fail_seen <= tick ? 1'b0 : cycle_failed;
        end
    end

    // ------------------------------------------------------------
    // bucket accumulator and decay
    // ------------------------------------------------------------
    logic [7:0] bucket;
    logic [2:0] clean_cnt;
    logic [7:0] next_bucket;
    logic [2:0] next_clean;

    wire [2:0] clean_last = 3'((4'h1 << decay_rate) - 4'h1);
    // a rate cut below the running count still ends the period
    wire period_done = (clean_cnt >= clean_last);
    // saturate at the top so a long outage cannot wrap to a clean count
    wire do_inc = tick && cycle_failed && (bucket != 8'hff);
    wire do_dec = tick && !cycle_failed && period_done && (bucket != 8'h00);

    always_comb begin
        next_bucket = bucket;
        next_clean = clean_cnt;
        if (tick) begin
            if (cycle_failed) begin
                next_clean = 3'h0;
                if (do_inc) begin
                    next_bucket = bucket + 8'h01;
                end
            end else if (period_done) begin
                next_clean = 3'h0;
                if (do_dec) begin
                    next_bucket = bucket - 8'h01;
                end
            end else begin
                next_clean = clean_cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            bucket <= 8'h00;
            clean_cnt <= 3'h0;
        end else if (I_CE) begin
            bucket <= next_bucket;
            clean_cnt <= next_clean;
        end
    end

    // ------------------------------------------------------------
    // alarm with hysteresis
    // ------------------------------------------------------------
    wire at_upper = (bucket >= set_level);
    wire at_lower = (bucket <= clear_level);
    // upper level wins if software programs the levels crossed
    wire next_alarm = at_upper ? 1'b1 : (at_lower ? 1'b0 : O_ALARM);
    wire ev_raise = next_alarm && !O_ALARM;
    wire ev_clear = !next_alarm && O_ALARM;

    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            O_ALARM <= 1'b0;
        end else if (I_CE) begin
            O_ALARM <= next_alarm;
        end
    end

    // ------------------------------------------------------------
    // interrupt status, cleared by read
    // ------------------------------------------------------------
    wire [lba_pkg::ST_W-1:0] events = {ev_clear, ev_raise};
    wire [lba_pkg::ST_W-1:0] st_keep = rd_status ? '0 : status;
    // an event in the reading cycle survives the clear
    wire [lba_pkg::ST_W-1:0] next_status = st_keep | events;
    // mask written this cycle takes effect with the same edge
    wire [lba_pkg::ST_W-1:0] next_mask = wr_mask ? I_HWDATA[lba_pkg::ST_W-1:0] : irq_mask;

    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            status <= '0;
            O_IRQ <= 1'b0;
        end else if (I_CE) begin
            status <= next_status;
            O_IRQ <= |(next_status & next_mask);
        end
    end

    // ------------------------------------------------------------
    // read data and response
    // ------------------------------------------------------------
    logic [31:0] rd_word;

    always_comb begin
        rd_word = 32'h0000_0000;
        if (acc.rd_idx == lba_pkg::IDX_SET_LEVEL) begin
            rd_word[7:0] = set_level;
        end else if (acc.rd_idx == lba_pkg::IDX_CLEAR_LEVEL) begin
            rd_word[7:0] = clear_level;
        end else if (acc.rd_idx == lba_pkg::IDX_DECAY) begin
            rd_word[lba_pkg::DECAY_W-1:0] = decay_rate;
        end else if (acc.rd_idx == lba_pkg::IDX_STATUS) begin
            rd_word[lba_pkg::ST_W-1:0] = status;
        end else if (acc.rd_idx == lba_pkg::IDX_MASK) begin
            rd_word[lba_pkg::ST_W-1:0] = irq_mask;
        end else if (acc.rd_idx == lba_pkg::IDX_STATE) begin
            rd_word[7:0] = bucket;
            rd_word[lba_pkg::STATE_ALARM_BIT] = O_ALARM;
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            O_HRDATA <= 32'h0000_0000;
            O_HREADYOUT <= 1'b1;
            O_HRESP <= 1'b0;
        end else if (I_CE) begin
            O_HRDATA <= acc.rd_stb ? rd_word : 32'h0000_0000;
            O_HREADYOUT <= 1'b1;
            O_HRESP <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RST_N);

    sequence s_failed_tick;
        I_CE && tick && cycle_failed && bucket != 8'hff;
    endsequence

    sequence s_clean_decay;
        I_CE && tick && !cycle_failed && period_done && bucket != 8'h00;
    endsequence

    a_fail_capture: assert property (
        (I_CE && I_FAIL && !tick) ##1 (I_CE && !tick) |-> fail_seen)
        else $error("failure inside cycle was not remembered");

    a_bucket_inc: assert property (
        s_failed_tick |=> bucket == $past(bucket) + 8'h01)
        else $error("bucket did not count a failed cycle");

    a_bucket_dec: assert property (
        s_clean_decay |=> bucket == $past(bucket) - 8'h01)
        else $error("bucket did not decay after clean period");

    a_decay_rate_one: assert property (
        (I_CE && tick && !cycle_failed && decay_rate == 2'h0 && bucket != 8'h00)
        |=> bucket != $past(bucket))
        else $error("fastest decay skipped a clean cycle");

    a_floor_zero: assert property (
        (I_CE && bucket == 8'h00 && !(tick && cycle_failed)) |=> bucket == 8'h00)
        else $error("bucket left zero without failure");

    a_alarm_raise: assert property (
        (I_CE && bucket >= set_level) |=> O_ALARM)
        else $error("alarm not raised at upper level");

    a_alarm_clear: assert property (
        (I_CE && bucket <= clear_level && bucket < set_level) |=> !O_ALARM)
        else $error("alarm not cleared at lower level");

    a_alarm_hold: assert property (
        (I_CE && bucket > clear_level && bucket < set_level) |=> $stable(O_ALARM))
        else $error("alarm changed between levels");

    a_reset_upper: assert property (
        $past(!I_RST_N) |-> set_level == 8'h06)
        else $error("upper level reset value wrong");

    a_reset_lower: assert property (
        $past(!I_RST_N) |-> clear_level == 8'h04)
        else $error("lower level reset value wrong");

    a_irq_follows: assert property (
        (I_CE && ev_raise && irq_mask[lba_pkg::ST_RAISE] && !wr_mask) |=> O_IRQ)
        else $error("masked-in raise event did not assert interrupt");

    a_tick_clears_fail: assert property (
        (I_CE && tick) |=> !fail_seen)
        else $error("failure memory not cleared at cycle end");

    a_clean_restart: assert property (
        (I_CE && tick && cycle_failed) |=> clean_cnt == 3'h0)
        else $error("clean period not restarted by failed cycle");

    a_clean_count: assert property (
        (I_CE && tick && !cycle_failed && !period_done)
        |=> clean_cnt == $past(clean_cnt) + 3'h1)
        else $error("clean cycle not counted");

    a_bucket_quiet: assert property (
        (I_CE && !tick) |=> $stable(bucket))
        else $error("bucket moved outside a cycle end");

    a_status_raise: assert property (
        (I_CE && ev_raise) |=> status[lba_pkg::ST_RAISE])
        else $error("raise event not recorded");

    a_status_clear: assert property (
        (I_CE && ev_clear) |=> status[lba_pkg::ST_CLEAR])
        else $error("clear event not recorded");

    a_read_clears: assert property (
        (I_CE && rd_status && !ev_raise && !ev_clear) |=> status == '0)
        else $error("status not cleared by read");

    a_irq_level: assert property (
        O_IRQ == |(status & irq_mask))
        else $error("interrupt does not match unmasked status");

    a_freeze_all: assert property (
        !I_CE |=> $stable(bucket) && $stable(O_ALARM) && $stable(status) && $stable(set_level))
        else $error("state moved while clock enable low");

    a_bus_okay: assert property (
        O_HREADYOUT && !O_HRESP)
        else $error("bus answer not ready and okay");
endmodule

// ===== lba_mon_model.sv
// Purpose: stand-in for the activity detector that feeds the alarm
// Assumes: period equals the alarm's shortened monitoring cycle
// Notes: a failed cycle shows one short glitch, not a held level
module lba_mon_model #(
    parameter int PERIOD = 32
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_bad,
    output logic o_fail,
    output logic o_start
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // cycle position
    // ------------------------------------------------------------
    logic [15:0] pos;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n || pos == 16'(PERIOD - 1)) begin
            pos <= 16'h0;
        end else begin
            pos <= pos + 16'h1;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // late glitch keeps clear of the cycle edge and of bench bus traffic
    assign o_fail = i_bad && (pos == 16'(PERIOD - 8));
    assign o_start = (pos == 16'h0);
endmodule

// ===== testbench.sv
// Purpose: self-checking bench for the leaky-bucket activity alarm
// Assumes: monitoring cycle shortened to 32 clocks
// Notes: bucket and alarm are read a few clocks into each cycle
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam int CYC = 32;
    typedef struct packed {
        logic [7:0] idx;
        logic [31:0] exp;
    } lba_row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic bad = 1'b0;
    logic ce = 1'b1;
    logic fail;
    logic start;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic alarm;
    logic irq;
    logic [31:0] rd;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    int b;
    lba_row_t rows [7];

    always #25 clk = ~clk;

    // ------------------------------------------------------------
    // design and partner
    // ------------------------------------------------------------
    lba_alarm #(.CYCLE_CLKS(CYC)) u_dut (
        .I_MCLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_FAIL(fail),
        .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
        .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hreadyout),
        .O_HRDATA(hrdata), .O_HREADYOUT(hreadyout), .O_HRESP(hresp),
        .O_ALARM(alarm), .O_IRQ(irq)
    );

    lba_mon_model #(.PERIOD(CYC)) u_mon (
        .i_clk(clk), .i_rst_n(rst_n), .i_bad(bad), .o_fail(fail), .o_start(start)
    );

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic ahb(input logic w, input logic [7:0] idx, input logic [2:0] sz,
                       input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'h0};
        htrans <= lba_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= sz;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rchk(input string name, input logic [7:0] idx, input logic [31:0] exp);
        ahb(1'b0, idx, lba_pkg::HSIZE_WORD, 32'h0);
        chk(name, rd, exp);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        ahb(1'b1, idx, lba_pkg::HSIZE_WORD, wd);
    endtask

    // judges the current cycle, returns just after the bucket has moved
    task automatic cyc(input logic bv);
        bad <= bv;
        @(posedge clk iff start);
        repeat (4) @(posedge clk);
    endtask

    task automatic summarize();
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // timeout
    // ------------------------------------------------------------
    // about 1200 clocks expected; generous margin for slow answers
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            errors++;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        rows = '{'{8'h50, 32'h6}, '{8'h51, 32'h4}, '{8'h53, 32'h1}, '{8'h60, 32'h0},
                 '{8'h61, 32'h0}, '{8'h62, 32'h0}, '{8'h70, 32'h0}};
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk("rdata idle", hrdata, 32'h0);
        chk("flags", {28'h0, hreadyout, hresp, alarm, irq}, 32'h8);
        foreach (rows[i]) begin
            rchk($sformatf("reg %h", rows[i].idx), rows[i].idx, rows[i].exp);
        end
        ahb(1'b1, lba_pkg::IDX_SET_LEVEL, 3'h0, 32'h33);
        rchk("byte write ignored", lba_pkg::IDX_SET_LEVEL, 32'h6);
        wr(lba_pkg::IDX_CLEAR_LEVEL, 32'h1ab);
        rchk("clear level rw", lba_pkg::IDX_CLEAR_LEVEL, 32'hab);
        wr(lba_pkg::IDX_CLEAR_LEVEL, 32'h4);
        wr(lba_pkg::IDX_MASK, 32'h1);
        wr(lba_pkg::IDX_DECAY, 32'h0);
        // align to the partner so each call covers exactly one cycle
        @(posedge clk iff start);
        for (int k = 1; k <= 6; k++) begin
            cyc(1'b1);
            rchk("bucket up", lba_pkg::IDX_STATE, 32'(k + (k >= 6 ? 256 : 0)));
            chk("alarm up", {31'h0, alarm}, 32'(k >= 6));
        end
        chk("irq raised", {31'h0, irq}, 32'h1);
        rchk("raise event", lba_pkg::IDX_STATUS, 32'h1);
        chk("irq after read", {31'h0, irq}, 32'h0);
        for (int i = 0; i < 7; i++) begin
            cyc(1'b0);
            b = (i < 6) ? 5 - i : 0;
            rchk("bucket down", lba_pkg::IDX_STATE, 32'(b + (b > 4 ? 256 : 0)));
            chk("alarm down", {31'h0, alarm}, 32'(b > 4));
            if (b == 4) begin
                chk("irq masked", {31'h0, irq}, 32'h0);
                rchk("clear event", lba_pkg::IDX_STATUS, 32'h2);
            end
        end
        for (int r = 0; r < 4; r++) begin
            wr(lba_pkg::IDX_DECAY, 32'(r));
            cyc(1'b1);
            for (int i = 1; i <= (1 << r); i++) begin
                cyc(1'b0);
                rchk("decay period", lba_pkg::IDX_STATE, 32'(i == (1 << r) ? 0 : 1));
            end
        end
        wr(lba_pkg::IDX_SET_LEVEL, 32'h2);
        wr(lba_pkg::IDX_CLEAR_LEVEL, 32'h0);
        cyc(1'b1);
        chk("low set level", {31'h0, alarm}, 32'h0);
        cyc(1'b1);
        chk("low set level", {31'h0, alarm}, 32'h1);
        // frozen enable must swallow a write; the partner drifts, so this runs after the last monitored cycle
        ce <= 1'b0;
        wr(lba_pkg::IDX_SET_LEVEL, 32'h7);
        ce <= 1'b1;
        rchk("frozen write", lba_pkg::IDX_SET_LEVEL, 32'h2);
        chk("frozen alarm", {31'h0, alarm}, 32'h1);
        // mid-run reset must bring both levels back
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rchk("reset upper", lba_pkg::IDX_SET_LEVEL, 32'h6);
        rchk("reset lower", lba_pkg::IDX_CLEAR_LEVEL, 32'h4);
        rchk("reset state", lba_pkg::IDX_STATE, 32'h0);
        chk("reset outputs", {30'h0, alarm, irq}, 32'h0);
        summarize();
    end
endmodule
